/* File: include/lbs_params.svh */
// Offsets, field positions, reset values and timing counts of the LED and supply block
`ifndef LBS_PARAMS_SVH
`define LBS_PARAMS_SVH
`define LBS_IDX_LED_MODE 8'h2B
`define LBS_IDX_BLINK 8'h2C
`define LBS_IDX_SUPPLY 8'h2D
`define LBS_BLINK_RST 8'h00
`define LBS_CROWBAR_RST 2'h3
`define LBS_CODE_1HZ 3'h3
`define LBS_F_LED_CFG 7
`define LBS_F_S45 6
`define LBS_F_LED_POL 7
`define LBS_F_LAST 6
`define LBS_F_POL 5
`define LBS_F_RESUME 2
`define LBS_F_OFF 1
`define LBS_F_BTN 0
`define LBS_CLK_HZ 100_000_000
`define LBS_TICKS_PER_S 24
`define LBS_TICK_CYCLES (`LBS_CLK_HZ / `LBS_TICKS_PER_S)
`define LBS_CROWBAR_MS0 500
`define LBS_CROWBAR_MS1 1000
`define LBS_CROWBAR_MS2 1250
`define LBS_CROWBAR_MS3 2000
`define LBS_MS_TICKS(ms) ((ms) * `LBS_TICKS_PER_S / 1000 + 1)
`endif

/* File: include/lbs_pkg.sv */
// Types shared by the LED and supply control block
package lbs_pkg;
  typedef enum logic [1:0] {
    LBS_MODE_SW = 2'b00,
    LBS_MODE_HW1 = 2'b01,
    LBS_MODE_HW2 = 2'b10,
    LBS_MODE_RSV = 2'b11
  } lbs_led_mode_t;
  typedef enum logic {
    LBS_BUS_IDLE = 1'b0,
    LBS_BUS_ACK = 1'b1
  } lbs_bus_state_t;
endpackage

/* File: include/lbs_blink_if.sv */
// Blink codes in, blink levels and time base tick out
`timescale 1ns/100ps
interface lbs_blink_if;
  logic [2:0] code_one;
  logic [2:0] code_two;
  logic level_one;
  logic level_two;
  logic tick;
  modport gen (input code_one, input code_two, output level_one, output level_two, output tick);
  modport user (output code_one, output code_two, input level_one, input level_two, input tick);
endinterface

/* File: hw/lbs_blink_gen.sv */
// Shared slow time base and the two blink-rate decoders
`timescale 1ns/100ps
`include "lbs_params.svh"
module lbs_blink_gen
  import lbs_pkg::*;
#(
  parameter int TICK_CYCLES = `LBS_TICK_CYCLES
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  lbs_blink_if.gen bl
);
  // Phase runs 0..95 in 1/24 s steps: one 4 s period of the slowest rate
  logic [26:0] pre_reg, pre_next;
  logic [6:0] ph_reg, ph_next;
  logic tick_reg, tick_next;
  logic lvl1_reg, lvl1_next, lvl2_reg, lvl2_next;

  function automatic logic blink_level(input logic [2:0] code, input logic [6:0] ph);
    case (code)
      3'h0: blink_level = 1'b0;
      3'h1: blink_level = (ph < 7'd12);
      3'h2: blink_level = ((ph % 7'd48) < 7'd12);
      3'h3: blink_level = ((ph % 7'd24) < 7'd12);
      3'h4: blink_level = ((ph % 7'd12) < 7'd6);
      3'h5: blink_level = ((ph % 7'd8) < 7'd4);
      3'h6: blink_level = ((ph % 7'd6) < 7'd3);
      default: blink_level = 1'b1;
    endcase
  endfunction

  always_comb begin
    tick_next = (pre_reg == 27'(TICK_CYCLES - 1));
    pre_next = tick_next ? 27'h000_0000 : pre_reg + 27'h000_0001;
    ph_next = ph_reg;
    if (tick_next) begin
      ph_next = (ph_reg == 7'd95) ? 7'h00 : ph_reg + 7'h01;
    end
    lvl1_next = blink_level(bl.code_one, ph_reg);
    lvl2_next = blink_level(bl.code_two, ph_reg);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_reg <= 27'h000_0000;
      ph_reg <= 7'h00;
      tick_reg <= 1'b0;
      lvl1_reg <= 1'b0;
      lvl2_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      ph_reg <= ph_next;
      tick_reg <= tick_next;
      lvl1_reg <= lvl1_next;
      lvl2_reg <= lvl2_next;
    end
  end

  assign bl.tick = tick_reg;
  assign bl.level_one = lvl1_reg;
  assign bl.level_two = lvl2_reg;

  code_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bl.code_two == 3'h0 |=> !bl.level_two) else $error("code 000 not low");
  code_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bl.code_one == 3'h7 |=> bl.level_one) else $error("code 111 not high");
  one_hz_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bl.code_one == 3'h3 && ph_reg == 7'd42) |=> !bl.level_one)
    else $error("1 Hz second half not low");
endmodule // lbs_blink_gen

/* File: hw/lbs_supply_led.sv */
// LED blink and power-supply-on control registers with their logic
`timescale 1ns/100ps
`include "lbs_params.svh"
module lbs_supply_led
  import lbs_pkg::*;
#(
  parameter int TICK_CYCLES = `LBS_TICK_CYCLES
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_main_power_good,
  input wire logic i_sleep_s3_in,
  input wire logic i_supply_on_polarity_strap,
  output logic o_supply_on_out,
  output logic o_indicator_one,
  output logic o_indicator_two
);
  // ****************************************
  // Register bus
  // ****************************************
  lbs_bus_state_t bus_reg, bus_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] idx;
  logic wr_go, wr_mode, wr_blink, wr_supply;

  // Battery-backed state; cleared only by the standby power-up reset
  lbs_led_mode_t mode_reg, mode_next;
  logic [7:0] blink_reg, blink_next;
  logic led_pol_reg, led_pol_next;
  logic last_reg, last_next;
  logic pol_reg, pol_next;
  logic strap_done_reg, strap_done_next;
  logic [1:0] crow_reg, crow_next;
  logic resume_reg, resume_next;
  logic btn_reg, btn_next;

  function automatic logic [7:0] read_mux(input logic [7:0] i);
    case (i)
      `LBS_IDX_LED_MODE: read_mux = {4'h0, mode_reg, 2'h0};
      `LBS_IDX_BLINK: read_mux = blink_reg;
      `LBS_IDX_SUPPLY: read_mux = {led_pol_reg, last_reg & ~btn_reg, pol_reg,
                                   crow_reg, resume_reg, 1'b0, btn_reg};
      default: read_mux = 8'h00;
    endcase
  endfunction

  assign idx = i_avs_address[9:2];
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_reg != LBS_BUS_ACK);
  assign wr_go = i_avs_write & (bus_reg == LBS_BUS_ACK);
  assign wr_mode = wr_go & (idx == `LBS_IDX_LED_MODE);
  assign wr_blink = wr_go & (idx == `LBS_IDX_BLINK);
  assign wr_supply = wr_go & (idx == `LBS_IDX_SUPPLY);

  always_comb begin
    bus_next = bus_reg;
    rdata_next = rdata_reg;
    case (bus_reg)
      LBS_BUS_IDLE: begin
        if (i_avs_read | i_avs_write) begin
          bus_next = LBS_BUS_ACK;
        end
        if (i_avs_read) begin
          rdata_next = {24'h00_0000, read_mux(idx)};
        end
      end
      LBS_BUS_ACK: bus_next = LBS_BUS_IDLE;
      default: bus_next = LBS_BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_reg <= LBS_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_avs_readdata = rdata_reg;

  // ****************************************
  // Power events and time base
  // ****************************************
  logic pg_prev_reg, s3_prev_reg;
  logic power_up, power_drop, s3_change;
  lbs_blink_if bl ();

  // First edge after reset sees a main power rise and settles on from the sleep input
  assign power_up = i_main_power_good & ~pg_prev_reg;
  assign power_drop = ~i_main_power_good & pg_prev_reg;
  assign s3_change = i_sleep_s3_in ^ s3_prev_reg;

  lbs_blink_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_blink (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bl(bl)
  );

  // ****************************************
  // Configuration registers
  // ****************************************
  logic on_reg, on_next;

  always_comb begin
    mode_next = mode_reg;
    blink_next = blink_reg;
    led_pol_next = led_pol_reg;
    last_next = last_reg;
    pol_next = pol_reg;
    strap_done_next = 1'b1;
    crow_next = crow_reg;
    resume_next = resume_reg;
    btn_next = btn_reg;
    if (!strap_done_reg) begin
      pol_next = i_supply_on_polarity_strap;
    end
    if (wr_mode) begin
      mode_next = lbs_led_mode_t'(i_avs_writedata[3:2]);
    end
    if (wr_blink) begin
      blink_next = i_avs_writedata[7:0];
    end
    // Hardware load wins over a software write in the same cycle
    if (power_drop && mode_reg == LBS_MODE_HW1) begin
      blink_next[5:3] = `LBS_CODE_1HZ;
    end
    if (wr_supply) begin
      led_pol_next = i_avs_writedata[`LBS_F_LED_POL];
      crow_next = i_avs_writedata[4:3];
      resume_next = i_avs_writedata[`LBS_F_RESUME];
      btn_next = i_avs_writedata[`LBS_F_BTN];
    end
    if (power_drop) begin
      last_next = on_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= LBS_MODE_SW;
      blink_reg <= `LBS_BLINK_RST;
      led_pol_reg <= 1'b0;
      last_reg <= 1'b0;
      pol_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      crow_reg <= `LBS_CROWBAR_RST;
      resume_reg <= 1'b0;
      btn_reg <= 1'b0;
      pg_prev_reg <= 1'b0;
      s3_prev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      blink_reg <= blink_next;
      led_pol_reg <= led_pol_next;
      last_reg <= last_next;
      pol_reg <= pol_next;
      strap_done_reg <= strap_done_next;
      crow_reg <= crow_next;
      resume_reg <= resume_next;
      btn_reg <= btn_next;
      pg_prev_reg <= i_main_power_good;
      s3_prev_reg <= i_sleep_s3_in;
    end
  end

  // ****************************************
  // Supply-on control and crowbar
  // ****************************************
  logic [5:0] crow_cnt_reg, crow_cnt_next;
  logic [5:0] crow_limit;
  logic off_cmd, crow_trip;
  logic pin_reg, pin_next;

  function automatic logic [5:0] crow_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: crow_ticks = 6'(`LBS_MS_TICKS(`LBS_CROWBAR_MS0));
      2'h1: crow_ticks = 6'(`LBS_MS_TICKS(`LBS_CROWBAR_MS1));
      2'h2: crow_ticks = 6'(`LBS_MS_TICKS(`LBS_CROWBAR_MS2));
      default: crow_ticks = 6'(`LBS_MS_TICKS(`LBS_CROWBAR_MS3));
    endcase
  endfunction

  assign crow_limit = crow_ticks(crow_reg);
  assign off_cmd = wr_supply & i_avs_writedata[`LBS_F_OFF] & ~btn_reg;
  // Compare with >= so a limit lowered in mid-count still trips
  assign crow_trip = on_reg & ~i_main_power_good & (crow_cnt_reg >= crow_limit);

  always_comb begin
    on_next = on_reg;
    crow_cnt_next = crow_cnt_reg;
    if (s3_change) begin
      on_next = i_sleep_s3_in;
    end
    if (power_up) begin
      on_next = resume_reg ? last_reg : i_sleep_s3_in;
    end
    if (off_cmd || crow_trip) begin
      on_next = 1'b0;
    end
    if (!on_reg || i_main_power_good || crow_trip) begin
      crow_cnt_next = 6'h00;
    end else if (bl.tick) begin
      crow_cnt_next = crow_cnt_reg + 6'h01;
    end
    pin_next = pol_next ? on_next : ~on_next;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_reg <= 1'b0;
      crow_cnt_reg <= 6'h00;
      pin_reg <= 1'b0;
    end else begin
      on_reg <= on_next;
      crow_cnt_reg <= crow_cnt_next;
      pin_reg <= pin_next;
    end
  end

  assign o_supply_on_out = pin_reg;

  // ****************************************
  // Indicator outputs
  // ****************************************
  logic lit1, lit2;
  logic ind1_reg, ind1_next, ind2_reg, ind2_next;

  assign bl.code_one = blink_reg[2:0];
  assign bl.code_two = blink_reg[5:3];

  always_comb begin
    lit1 = bl.level_one;
    lit2 = bl.level_two;
    if (mode_reg == LBS_MODE_HW2 && !blink_reg[`LBS_F_S45] && !on_reg) begin
      lit1 = 1'b0;
    end
    if (mode_reg == LBS_MODE_RSV) begin
      lit1 = 1'b0;
      lit2 = 1'b0;
    end
    if (!blink_reg[`LBS_F_LED_CFG] && lit1) begin
      lit2 = 1'b0;
    end
    ind1_next = lit1 ^ led_pol_reg;
    ind2_next = lit2 ^ led_pol_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ind1_reg <= 1'b0;
      ind2_reg <= 1'b0;
    end else begin
      ind1_reg <= ind1_next;
      ind2_reg <= ind2_next;
    end
  end

  assign o_indicator_one = ind1_reg;
  assign o_indicator_two = ind2_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_off_write;
    wr_supply && i_avs_writedata[`LBS_F_OFF] && !btn_reg;
  endsequence
  sequence s_resume_up;
    power_up && resume_reg && !s3_change;
  endsequence
  sequence s_supply_read;
    i_avs_read && idx == `LBS_IDX_SUPPLY && bus_reg == LBS_BUS_IDLE;
  endsequence
  sequence s_power_fail;
    power_drop;
  endsequence

  s45_led_off_a: assert property (mode_reg == LBS_MODE_HW2 && !blink_reg[6] && !on_reg
    |=> o_indicator_one == $past(led_pol_reg)) else $error("power LED lit in S4/S5");
  hw1_load_a: assert property (power_drop && mode_reg == LBS_MODE_HW1
    |=> blink_reg[5:3] == 3'h3) else $error("1 Hz code not loaded");
  led_pol_a: assert property (blink_reg[2:0] == 3'h0 && mode_reg == LBS_MODE_SW
    ##1 blink_reg[2:0] == 3'h0 |=> o_indicator_one == $past(led_pol_reg))
    else $error("LED polarity wrong");
  last_read_a: assert property (s_supply_read |=> o_avs_readdata[6] ==
    ($past(last_reg) && !$past(btn_reg)) && o_avs_readdata[1] == 1'b0)
    else $error("bad read");
  strap_pol_a: assert property ($rose(strap_done_reg) |-> pol_reg ==
    $past(i_supply_on_polarity_strap)) else $error("strap not latched");
  pin_pol_a: assert property (strap_done_reg |->
    o_supply_on_out == (pol_reg ? on_reg : !on_reg)) else $error("supply pin polarity wrong");
  crowbar_cnt_a: assert property (crow_cnt_reg <= crow_limit || $past(wr_supply))
    else $error("crowbar count past limit");
  resume_a: assert property ((s_resume_up and !off_cmd) |=> on_reg == $past(last_reg))
    else $error("last state not resumed");
  power_off_a: assert property (s_off_write |=> !on_reg) else $error("off write ignored");
  bus_ack_a: assert property ((i_avs_read || i_avs_write) && bus_reg == LBS_BUS_IDLE
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("no answer in 2 cycles");
  dual_led_a: assert property (!blink_reg[7] && !led_pol_reg |=>
    !(o_indicator_one && o_indicator_two)) else $error("dual LED both lit");
  last_capture_a: assert property (s_power_fail |=> last_reg == $past(on_reg))
    else $error("last state not captured");
  crowbar_trip_a: assert property (crow_trip |=> !on_reg)
    else $error("crowbar did not trip");
  s3_follow_a: assert property (s3_change && !power_up && !off_cmd && !crow_trip
    |=> on_reg == $past(i_sleep_s3_in)) else $error("supply on not following S3");
  rsv_dark_a: assert property (mode_reg == LBS_MODE_RSV |=>
    o_indicator_one == $past(led_pol_reg) && o_indicator_two == $past(led_pol_reg))
    else $error("reserved mode LED lit");
  two_pol_a: assert property (blink_reg[5:3] == 3'h0 |=> ##1
    o_indicator_two == $past(led_pol_reg)) else $error("LED two polarity wrong");
endmodule // lbs_supply_led

/* File: testbench/lbs_psu_model.sv */
// Power supply and chipset sleep signal model at the far side of the block
`timescale 1ns/100ps
module lbs_psu_model (
  input wire logic i_clk,
  output logic o_main_power_good,
  output logic o_sleep_s3_in
);
  initial begin
    o_main_power_good = 1'b1;
    o_sleep_s3_in = 1'b0;
  end

  task set_s3(input logic v);
    @(posedge i_clk);
    o_sleep_s3_in <= v;
  endtask

  // Mains lost; a chipset set to resume off also drops its sleep signal
  task ac_fail(input logic chipset_off);
    @(posedge i_clk);
    o_main_power_good <= 1'b0;
    if (chipset_off) begin
      o_sleep_s3_in <= 1'b0;
    end
  endtask

  task ac_return;
    repeat (4) @(posedge i_clk);
    o_main_power_good <= 1'b1;
  endtask
endmodule // lbs_psu_model

/* File: testbench/lbs_supply_led_tb.sv */
// Register and pin level tests of the LED blink and supply control block
`timescale 1ns/100ps
`include "lbs_params.svh"
module lbs_supply_led_tb import lbs_pkg::*;;
  localparam int TICK = 4;
  localparam logic [9:0] A_MODE = {`LBS_IDX_LED_MODE, 2'b00};
  localparam logic [9:0] A_BLK = {`LBS_IDX_BLINK, 2'b00};
  localparam logic [9:0] A_SUP = {`LBS_IDX_SUPPLY, 2'b00};
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [9:0] address = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  logic pg;
  logic s3;
  logic strap = 1'b1;
  logic son;
  logic ind1;
  logic ind2;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int exp_hi[8] = '{0, 48, 96, 192, 192, 192, 192, 384};
  int exp_ris[8] = '{0, 1, 2, 4, 8, 12, 16, 0};
  int thr[4] = '{13, 25, 31, 49};

  always #5 i_clk = ~i_clk;

  lbs_supply_led #(.TICK_CYCLES(TICK)) lbs_supply_led_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(address), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_main_power_good(pg), .i_sleep_s3_in(s3),
    .i_supply_on_polarity_strap(strap), .o_supply_on_out(son),
    .o_indicator_one(ind1), .o_indicator_two(ind2));

  lbs_psu_model lbs_psu_model_i (.i_clk(i_clk), .o_main_power_good(pg), .o_sleep_s3_in(s3));

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge i_clk);
    address <= a;
    wdata <= {24'hA5_A5A5, d};
    wr <= w;
    rd <= ~w;
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task bus_wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (4) @(posedge i_clk);
  endtask

  task rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(name, q, exp);
  endtask

  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [2:0] code;
    logic prev;
    int hi;
    int ris;
    int apart;
    int n;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk("mode reset", A_MODE, 32'h0000_0000);
    rd_chk("blink reset", A_BLK, 32'h0000_0000);
    rd_chk("supply reset", A_SUP, 32'h0000_0038);
    bus_wr(10'h000, 8'hFF);
    rd_chk("unmapped", 10'h000, 32'h0000_0000);
    bus_wr(A_SUP, 8'hFF);
    rd_chk("supply ro bits", A_SUP | 10'h003, 32'h0000_00BD);
    bus_wr(A_SUP, 8'h18);
    // Fixed levels in software, HW2 and reserved LED modes, supply off
    bus_wr(A_BLK, 8'hBF);
    check("sw mode one", ind1, 1'b1);
    check("sw mode two", ind2, 1'b1);
    bus_wr(A_MODE, {4'h0, LBS_MODE_HW2, 2'b00});
    check("hw2 off one", ind1, 1'b0);
    bus_wr(A_BLK, 8'hFF);
    check("hw2 unchanged", ind1, 1'b1);
    bus_wr(A_MODE, {4'h0, LBS_MODE_RSV, 2'b00});
    check("rsv one", ind1, 1'b0);
    check("rsv two", ind2, 1'b0);
    bus_wr(A_MODE, {4'h0, LBS_MODE_SW, 2'b00});
    bus_wr(A_BLK, 8'h3F);
    check("dual two", ind2, 1'b0);
    bus_wr(A_SUP, 8'h98);
    bus_wr(A_BLK, 8'h80);
    check("pol one", ind1, 1'b1);
    check("pol two", ind2, 1'b1);
    bus_wr(A_SUP, 8'h18);
    // Blink rates over one full 4 s period
    for (int c = 0; c < 8; c++) begin
      code = c[2:0];
      bus_wr(A_BLK, {2'b10, code, code});
      hi = 0;
      ris = 0;
      apart = 0;
      prev = ind1;
      repeat (96 * TICK) begin
        @(posedge i_clk);
        if (ind1 === 1'b1) hi++;
        if (prev === 1'b0 && ind1 === 1'b1) ris++;
        if (ind1 !== ind2) apart++;
        prev = ind1;
      end
      check("high cycles", hi, exp_hi[c]);
      check("rising edges", ris, exp_ris[c]);
      check("in phase", apart, 0);
    end
    // Supply on control
    lbs_psu_model_i.set_s3(1'b1);
    repeat (3) @(posedge i_clk);
    check("on by s3", son, 1'b1);
    bus_wr(A_SUP, 8'h1A);
    check("power off", son, 1'b0);
    rd_chk("off reads 0", A_SUP, 32'h0000_0038);
    lbs_psu_model_i.set_s3(1'b0);
    lbs_psu_model_i.set_s3(1'b1);
    bus_wr(A_SUP, 8'h19);
    bus_wr(A_SUP, 8'h1B);
    check("acpi ignores off", son, 1'b1);
    bus_wr(A_SUP, 8'h1C);
    bus_wr(A_BLK, 8'h00);
    bus_wr(A_MODE, {4'h0, LBS_MODE_HW1, 2'b00});
    lbs_psu_model_i.ac_fail(1'b1);
    repeat (3) @(posedge i_clk);
    check("off after fail", son, 1'b0);
    rd_chk("last state", A_SUP, 32'h0000_007C);
    rd_chk("hw1 load", A_BLK, 32'h0000_0018);
    bus_wr(A_MODE, {4'h0, LBS_MODE_SW, 2'b00});
    lbs_psu_model_i.ac_return();
    repeat (3) @(posedge i_clk);
    check("resume last", son, 1'b1);
    bus_wr(A_SUP, 8'h18);
    lbs_psu_model_i.ac_fail(1'b1);
    lbs_psu_model_i.ac_return();
    repeat (3) @(posedge i_clk);
    check("follow s3", son, 1'b0);
    // Crowbar timeout per code
    for (int k = 0; k < 4; k++) begin
      bus_wr(A_SUP, {3'b000, k[1:0], 3'b000});
      lbs_psu_model_i.set_s3(1'b1);
      repeat (3) @(posedge i_clk);
      lbs_psu_model_i.ac_fail(1'b0);
      n = 0;
      while (son === 1'b1 && n < 300) begin
        @(posedge i_clk);
        n++;
      end
      check("crowbar", (n >= (thr[k] - 1) * TICK) && (n <= (thr[k] + 2) * TICK), 1);
      lbs_psu_model_i.ac_return();
      lbs_psu_model_i.set_s3(1'b0);
    end
    // Standby power cycle with the strap set for an active-low supply pin
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    strap <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk("strap low", A_SUP, 32'h0000_0018);
    check("off level low pol", son, 1'b1);
    lbs_psu_model_i.set_s3(1'b1);
    repeat (3) @(posedge i_clk);
    check("on level low pol", son, 1'b0);
    results();
  end
endmodule // lbs_supply_led_tb
